// >>> core/bkz_pkg.sv
// bank-zero configuration constants: offsets, field positions, reset values
// assumes an 8-bit register port with 7-bit addresses and bank selection done outside
package bkz_pkg;
    // register offsets
    localparam logic [6:0] OFF_WHITEN_CRC   = 7'h07;
    localparam logic [6:0] OFF_RF_RECEIVE_BIAS      = 7'h3c;
    localparam logic [6:0] OFF_PREAMBLE     = 7'h49;
    localparam logic [6:0] OFF_LF_MIN_CNT   = 7'h50;
    localparam logic [6:0] OFF_LF_MAX_CNT   = 7'h51;
    localparam logic [6:0] OFF_LF_THRESHOLD = 7'h52;
    localparam logic [6:0] OFF_LF_TX_DIV    = 7'h53;

    // whitening and crc control field positions
    localparam int BIT_BIT_ORDER    = 4;
    localparam int BIT_CRC_SEED     = 3;
    localparam int BIT_BYTE_REVERSE = 2;

    // reset values
    localparam logic       RST_BIT_ORDER    = 1'b1;
    localparam logic       RST_CRC_SEED     = 1'b0;
    localparam logic       RST_BYTE_REVERSE = 1'b1;
    localparam logic [7:0] RST_RF_RECEIVE_BIAS      = 8'h00;
    localparam logic [7:0] RST_PREAMBLE     = 8'h55;
    localparam logic [4:0] RST_LF_MIN_CNT   = 5'h06;
    localparam logic [4:0] RST_LF_MAX_CNT   = 5'h19;
    localparam logic [6:0] RST_LF_THRESHOLD = 7'h12;
    localparam logic [7:0] RST_LF_TX_DIV    = 8'h1f;

    // crc seeds
    localparam logic [15:0] CRC_SEED_ZEROS = 16'h0000;
    localparam logic [15:0] CRC_SEED_ONES  = 16'hffff;

    // lf preamble window: carrier cycles measured
    localparam logic [1:0] LF_WINDOW_CYCLES = 2'h3;

    // lf receive states, gray along idle-listen-header-data
    typedef enum logic [1:0] {
        BKZ_LF_IDLE   = 2'b00,
        BKZ_LF_LISTEN = 2'b01,
        BKZ_LF_HEADER = 2'b11,
        BKZ_LF_DATA   = 2'b10
    } bkz_lf_state_t;
endpackage : bkz_pkg

// >>> core/bkz_chip_timer.sv
// lf transmit chip timer: one chip per (divider+1)/2 carrier cycles, one carrier cycle when the divider is zero
// assumes lf_carrier_tick is a one-cycle pulse per lf carrier clock cycle
`timescale 1ns/1ps
module bkz_chip_timer (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       run,
    input  wire logic [7:0] divider,
    input  wire logic       lf_carrier_tick,
    // chip output
    output logic            chip_strobe,
    output logic            chip_odd
);
    logic [8:0] eff_div;
    logic [8:0] half_len;
    logic [8:0] chip_len;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic       odd_reg;
    logic       odd_next;
    logic       strobe_reg;
    logic       strobe_next;

    // [RL12] zero acts as one
    assign eff_div = (divider == 8'h00) ? 9'h002 : {1'b0, divider} + 9'h001;
    assign half_len = {1'b0, eff_div[8:1]};
    // [RL11] odd chip gets one extra cycle
    // parity taken from the effective divider: zero acts as one, never lengthened
    assign chip_len = (chip_odd && eff_div[0]) ? half_len + 9'h001 : half_len;

    always_comb begin
        cnt_next    = cnt_reg;
        odd_next    = odd_reg;
        strobe_next = 1'b0;
        if (!run) begin
            cnt_next = 9'h000;
            odd_next = 1'b0;
        end else if (lf_carrier_tick) begin
            // [RL10] chip at twice carrier over divider plus one
            if (cnt_reg + 9'h001 >= chip_len) begin
                cnt_next    = 9'h000;
                odd_next    = !odd_reg;
                strobe_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 9'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_reg    <= 9'h000;
            odd_reg    <= 1'b0;
            strobe_reg <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            odd_reg    <= odd_next;
            strobe_reg <= strobe_next;
        end
    end

    assign chip_strobe = strobe_reg;
    assign chip_odd    = !odd_reg;

    // [RL10] strobe only after a carrier tick
    chk_strobe_cause : assert property (@(posedge clk) disable iff (!rst_b)
        chip_strobe |-> $past(lf_carrier_tick) && $past(run))
        else $error("chip strobe without carrier tick");
    // [RL12] zero divider gives one-cycle chips
    chk_zero_div_rate : assert property (@(posedge clk) disable iff (!rst_b)
        (run && divider == 8'h00 && lf_carrier_tick && $stable(divider) && $past(run))
        |=> chip_strobe)
        else $error("zero divider not handled as one");
endmodule : bkz_chip_timer

// >>> core/bkz_bank_regs.sv
// bank-zero configuration registers with whitening, crc seed, preamble and lf logic
// assumes a byte-wide register port already decoded for bank zero, one access per cycle
// Function
// [RL1] whitening sequence is sent lsb first when the order bit is 0, msb first when 1, reset 1.
// [RL2] crc starts at all zeros when the seed bit is 0 and all ones when 1, reset 0.
// [RL3] with the byte-reverse bit set (reset state) each whitening byte is bit-reversed.
// [RL4] unused bits of the whitening and crc control register read as zero.
// [RL5] host must write the rf_receive_bias register with the enabling value before rf reception.
// [RL6] the preamble byte is sent the programmed number of times, resetting to 0x55.
// [RL7] an lf preamble count below the minimum setting (reset 6) is invalid.
// [RL8] an lf preamble count above the maximum setting (reset 25) is invalid.
// [RL9] the manchester decoder compares symbol lengths to the 7-bit threshold, reset 18.
// [RL10] lf chips come at twice the carrier rate divided by the divider plus one, reset 31.
// [RL11] with an even divider every odd chip is one carrier cycle longer.
// [RL12] a divider of zero behaves as a divider of one.
// [RL13] lf receive leaves preamble listening for header check only on a valid preamble.
// [RL14] rc periods are counted over three carrier cycles and accepted inside min..max.
`timescale 1ns/1ps
module bkz_bank_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [6:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    // whitening and crc
    input  wire logic [8:0]  pn_state,
    output logic [7:0]       whiten_byte,
    output logic [15:0]      crc_seed,
    // rf
    output logic [7:0]       rf_receive_bias,
    // preamble transmit
    input  wire logic [7:0]  preamble_repeat_length,
    input  wire logic        preamble_start,
    input  wire logic        preamble_byte_taken,
    output logic [7:0]       preamble_byte,
    output logic             preamble_active,
    // lf receive
    input  wire logic        lf_enable,
    input  wire logic        lf_carrier_tick,
    input  wire logic        lf_rc_tick,
    input  wire logic        lf_header_ok,
    input  wire logic [6:0]  lf_symbol_len,
    output logic             lf_symbol_long,
    output logic [1:0]       lf_receive_fsm_state,
    // lf transmit
    input  wire logic        lf_tx_run,
    output logic             lf_chip_strobe,
    output logic             lf_chip_odd
);
    logic       bit_order_reg,    bit_order_next;
    logic       crc_seed_reg,     crc_seed_next;
    logic       byte_rev_reg,     byte_rev_next;
    logic [7:0] bias_reg,         bias_next;
    logic [7:0] pre_reg,          pre_next;
    logic [4:0] min_reg,          min_next;
    logic [4:0] max_reg,          max_next;
    logic [6:0] thr_reg,          thr_next;
    logic [7:0] div_reg,          div_next;
    logic [7:0] rdata_reg,        rdata_next;
    logic [7:0] wh_reg,           wh_next;
    logic [7:0] rep_reg,          rep_next;
    logic [1:0] win_reg,          win_next;
    logic [5:0] rc_cnt_reg,       rc_cnt_next;
    logic       sym_reg,          sym_next;
    bkz_pkg::bkz_lf_state_t st_reg, st_next;
    logic [7:0] pn_low;
    logic [7:0] pn_rev;
    logic [7:0] pn_sel;
    logic       count_ok;

    // register writes
    always_comb begin
        bit_order_next = bit_order_reg;
        crc_seed_next  = crc_seed_reg;
        byte_rev_next  = byte_rev_reg;
        bias_next      = bias_reg;
        pre_next       = pre_reg;
        min_next       = min_reg;
        max_next       = max_reg;
        thr_next       = thr_reg;
        div_next       = div_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                bkz_pkg::OFF_WHITEN_CRC: begin
                    bit_order_next = reg_wdata[bkz_pkg::BIT_BIT_ORDER];
                    crc_seed_next  = reg_wdata[bkz_pkg::BIT_CRC_SEED];
                    byte_rev_next  = reg_wdata[bkz_pkg::BIT_BYTE_REVERSE];
                end
                // [RL5] bias stored for the host to enable rx
                bkz_pkg::OFF_RF_RECEIVE_BIAS:      bias_next = reg_wdata;
                bkz_pkg::OFF_PREAMBLE:     pre_next  = reg_wdata;
                bkz_pkg::OFF_LF_MIN_CNT:   min_next  = reg_wdata[4:0];
                bkz_pkg::OFF_LF_MAX_CNT:   max_next  = reg_wdata[4:0];
                bkz_pkg::OFF_LF_THRESHOLD: thr_next  = reg_wdata[6:0];
                bkz_pkg::OFF_LF_TX_DIV:    div_next  = reg_wdata;
                default: ;
            endcase
        end
    end

    // register reads, one cycle latency
    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            // [RL4] unused bits read zero
            bkz_pkg::OFF_WHITEN_CRC: begin
                rdata_next[bkz_pkg::BIT_BIT_ORDER]    = bit_order_reg;
                rdata_next[bkz_pkg::BIT_CRC_SEED]     = crc_seed_reg;
                rdata_next[bkz_pkg::BIT_BYTE_REVERSE] = byte_rev_reg;
            end
            bkz_pkg::OFF_RF_RECEIVE_BIAS:      rdata_next = bias_reg;
            bkz_pkg::OFF_PREAMBLE:     rdata_next = pre_reg;
            bkz_pkg::OFF_LF_MIN_CNT:   rdata_next = {3'h0, min_reg};
            bkz_pkg::OFF_LF_MAX_CNT:   rdata_next = {3'h0, max_reg};
            bkz_pkg::OFF_LF_THRESHOLD: rdata_next = {1'b0, thr_reg};
            bkz_pkg::OFF_LF_TX_DIV:    rdata_next = div_reg;
            default:                   rdata_next = 8'h00;
        endcase
    end

    // whitening byte from pn state
    assign pn_low = pn_state[7:0];
    generate
        for (genvar i = 0; i < 8; i++) begin : g_rev
            assign pn_rev[i] = pn_low[7 - i];
        end
    endgenerate
    always_comb begin
        // [RL1] bit order select
        pn_sel = bit_order_reg ? pn_rev : pn_low;
        // [RL3] byte reversal
        wh_next = byte_rev_reg ? {pn_sel[0], pn_sel[1], pn_sel[2], pn_sel[3],
                                  pn_sel[4], pn_sel[5], pn_sel[6], pn_sel[7]} : pn_sel;
    end

    // [RL6] preamble repeat counter
    always_comb begin
        rep_next = rep_reg;
        if (preamble_start) begin
            rep_next = preamble_repeat_length;
        end else if (preamble_byte_taken && rep_reg != 8'h00) begin
            rep_next = rep_reg - 8'h01;
        end
    end

    // [RL14] inclusive window check
    assign count_ok = (rc_cnt_reg >= {1'b0, min_reg}) && (rc_cnt_reg <= {1'b0, max_reg});

    // lf receive: rc count over three carrier cycles
    always_comb begin
        st_next     = st_reg;
        win_next    = win_reg;
        rc_cnt_next = rc_cnt_reg;
        sym_next    = sym_reg;
        // [RL9] threshold compare
        sym_next = lf_symbol_len > thr_reg;
        if (!lf_enable) begin
            st_next     = bkz_pkg::BKZ_LF_IDLE;
            win_next    = 2'h0;
            rc_cnt_next = 6'h00;
        end else begin
            unique case (st_reg)
                bkz_pkg::BKZ_LF_IDLE: st_next = bkz_pkg::BKZ_LF_LISTEN;
                bkz_pkg::BKZ_LF_LISTEN: begin
                    if (lf_rc_tick && rc_cnt_reg != 6'h3f) begin
                        rc_cnt_next = rc_cnt_reg + 6'h01;
                    end
                    if (lf_carrier_tick) begin
                        if (win_reg == bkz_pkg::LF_WINDOW_CYCLES - 2'h1) begin
                            win_next    = 2'h0;
                            rc_cnt_next = 6'h00;
                            // [RL7] [RL8] [RL13] only a valid count advances
                            if (count_ok) begin
                                st_next = bkz_pkg::BKZ_LF_HEADER;
                            end
                        end else begin
                            win_next = win_reg + 2'h1;
                        end
                    end
                end
                bkz_pkg::BKZ_LF_HEADER: begin
                    if (lf_header_ok) begin
                        st_next = bkz_pkg::BKZ_LF_DATA;
                    end
                end
                bkz_pkg::BKZ_LF_DATA: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bit_order_reg <= bkz_pkg::RST_BIT_ORDER;
            crc_seed_reg  <= bkz_pkg::RST_CRC_SEED;
            byte_rev_reg  <= bkz_pkg::RST_BYTE_REVERSE;
            bias_reg      <= bkz_pkg::RST_RF_RECEIVE_BIAS;
            pre_reg       <= bkz_pkg::RST_PREAMBLE;
            min_reg       <= bkz_pkg::RST_LF_MIN_CNT;
            max_reg       <= bkz_pkg::RST_LF_MAX_CNT;
            thr_reg       <= bkz_pkg::RST_LF_THRESHOLD;
            div_reg       <= bkz_pkg::RST_LF_TX_DIV;
            rdata_reg     <= 8'h00;
            wh_reg        <= 8'h00;
            rep_reg       <= 8'h00;
            win_reg       <= 2'h0;
            rc_cnt_reg    <= 6'h00;
            sym_reg       <= 1'b0;
            st_reg        <= bkz_pkg::BKZ_LF_IDLE;
        end else begin
            bit_order_reg <= bit_order_next;
            crc_seed_reg  <= crc_seed_next;
            byte_rev_reg  <= byte_rev_next;
            bias_reg      <= bias_next;
            pre_reg       <= pre_next;
            min_reg       <= min_next;
            max_reg       <= max_next;
            thr_reg       <= thr_next;
            div_reg       <= div_next;
            rdata_reg     <= rdata_next;
            wh_reg        <= wh_next;
            rep_reg       <= rep_next;
            win_reg       <= win_next;
            rc_cnt_reg    <= rc_cnt_next;
            sym_reg       <= sym_next;
            st_reg        <= st_next;
        end
    end

    // [RL10] lf transmit chip timing
    bkz_chip_timer u_chip_timer (
        .clk             (clk),
        .rst_b           (rst_b),
        .run             (lf_tx_run),
        .divider         (div_reg),
        .lf_carrier_tick (lf_carrier_tick),
        .chip_strobe     (lf_chip_strobe),
        .chip_odd        (lf_chip_odd)
    );

    assign reg_rdata            = rdata_reg;
    assign whiten_byte          = wh_reg;
    // [RL2] crc seed select
    assign crc_seed             = crc_seed_reg ? bkz_pkg::CRC_SEED_ONES : bkz_pkg::CRC_SEED_ZEROS;
    assign rf_receive_bias      = bias_reg;
    assign preamble_byte        = pre_reg;
    assign preamble_active      = rep_reg != 8'h00;
    assign lf_symbol_long       = sym_reg;
    assign lf_receive_fsm_state = st_reg;

    // [RL4]
    chk_ctrl_unused_zero : assert property (@(posedge clk) disable iff (!rst_b)
        $past(reg_addr) == bkz_pkg::OFF_WHITEN_CRC && $past(rst_b)
        |-> reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0)
        else $error("unused control bits not zero");
    // [RL2]
    chk_crc_seed_ones : assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && reg_addr == bkz_pkg::OFF_WHITEN_CRC && reg_wdata[3]
        |=> crc_seed == 16'hffff)
        else $error("crc seed not all ones");
    // [RL1]
    chk_pn_msb_first : assert property (@(posedge clk) disable iff (!rst_b)
        bit_order_reg && !byte_rev_reg |=> whiten_byte[7] == $past(pn_state[0]))
        else $error("whitening bit order wrong");
    // [RL3]
    chk_pn_byte_rev : assert property (@(posedge clk) disable iff (!rst_b)
        !bit_order_reg && byte_rev_reg |=> whiten_byte[0] == $past(pn_state[7]))
        else $error("whitening byte reversal wrong");
    // [RL6]
    chk_preamble_load : assert property (@(posedge clk) disable iff (!rst_b)
        preamble_start && preamble_repeat_length != 8'h00 |=> preamble_active)
        else $error("preamble repeat not loaded");
    // [RL7]
    chk_min_reject : assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == bkz_pkg::BKZ_LF_LISTEN && lf_enable && rc_cnt_reg < {1'b0, min_reg}
        |=> st_reg != bkz_pkg::BKZ_LF_HEADER)
        else $error("short preamble accepted");
    // [RL8]
    chk_max_reject : assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == bkz_pkg::BKZ_LF_LISTEN && lf_enable && rc_cnt_reg > {1'b0, max_reg}
        |=> st_reg != bkz_pkg::BKZ_LF_HEADER)
        else $error("long preamble accepted");
    // [RL13]
    chk_header_entry : assert property (@(posedge clk) disable iff (!rst_b)
        st_reg == bkz_pkg::BKZ_LF_HEADER && $past(st_reg) != bkz_pkg::BKZ_LF_HEADER
        |-> $past(st_reg) == bkz_pkg::BKZ_LF_LISTEN && $past(count_ok) && $past(lf_carrier_tick))
        else $error("header state entered without valid preamble");
    // [RL9]
    chk_symbol_thresh : assert property (@(posedge clk) disable iff (!rst_b)
        lf_symbol_len > thr_reg |=> lf_symbol_long)
        else $error("threshold compare wrong");
endmodule : bkz_bank_regs

// >>> sim/bkz_host_model.sv
// host side of the register port: byte writes and registered reads
// assumes one task call at a time, started only after reset release
`timescale 1ns/1ps
module bkz_host_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // register port
    output logic [6:0]      reg_addr,
    output logic            reg_wr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 7'h00;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        wait (rst_b === 1'b1);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        // released data no longer shows the written byte
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        wait (rst_b === 1'b1);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask : rd

    task automatic bias_enable();
        wr(bkz_pkg::OFF_RF_RECEIVE_BIAS, 8'h99);
    endtask : bias_enable
endmodule : bkz_host_model

// >>> sim/bkz_bank_regs_test.sv
// self-checking bench for the bank-zero configuration registers
// assumes the host model drives the register port, the bench drives the rest
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module bkz_bank_regs_test;
    logic        clk = 1'b0;
    logic        rst_b;
    logic [6:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [8:0]  pn_state;
    logic [7:0]  whiten_byte;
    logic [15:0] crc_seed;
    logic [7:0]  rf_receive_bias;
    logic [7:0]  preamble_repeat_length;
    logic        preamble_start;
    logic        preamble_byte_taken;
    logic [7:0]  preamble_byte;
    logic        preamble_active;
    logic        lf_enable;
    logic        lf_carrier_tick;
    logic        lf_rc_tick;
    logic        lf_header_ok;
    logic [6:0]  lf_symbol_len;
    logic        lf_symbol_long;
    logic [1:0]  lf_receive_fsm_state;
    logic        lf_tx_run;
    logic        lf_chip_strobe;
    logic        lf_chip_odd;
    int          fails = 0;
    int          comparisons = 0;
    int          strb;
    logic [7:0]  rv;
    logic [6:0]  offs [8] = '{7'h07, 7'h3c, 7'h49, 7'h50, 7'h51, 7'h52, 7'h53, 7'h08};
    logic [7:0]  rstv [8] = '{8'h14, 8'h00, 8'h55, 8'h06, 8'h19, 8'h12, 8'h1f, 8'h00};
    logic [7:0]  mskv [8] = '{8'h1c, 8'hff, 8'hff, 8'h1f, 8'h1f, 8'h7f, 8'hff, 8'h00};

    always #2 clk = ~clk;

    bkz_host_model HOST (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
                         .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    bkz_bank_regs DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pn_state(pn_state),
        .whiten_byte(whiten_byte), .crc_seed(crc_seed), .rf_receive_bias(rf_receive_bias),
        .preamble_repeat_length(preamble_repeat_length), .preamble_start(preamble_start),
        .preamble_byte_taken(preamble_byte_taken), .preamble_byte(preamble_byte),
        .preamble_active(preamble_active), .lf_enable(lf_enable),
        .lf_carrier_tick(lf_carrier_tick), .lf_rc_tick(lf_rc_tick),
        .lf_header_ok(lf_header_ok), .lf_symbol_len(lf_symbol_len),
        .lf_symbol_long(lf_symbol_long), .lf_receive_fsm_state(lf_receive_fsm_state),
        .lf_tx_run(lf_tx_run), .lf_chip_strobe(lf_chip_strobe), .lf_chip_odd(lf_chip_odd));

    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7 - i];
        return r;
    endfunction : rev8

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // one tick pulse; 0 carrier, 1 rc, 2 header, 3 start, 4 byte taken
    task automatic pulse(input int w);
        @(posedge clk);
        case (w)
            0: lf_carrier_tick <= 1'b1;
            1: lf_rc_tick <= 1'b1;
            2: lf_header_ok <= 1'b1;
            3: preamble_start <= 1'b1;
            default: preamble_byte_taken <= 1'b1;
        endcase
        #1 if (lf_chip_strobe === 1'b1) strb++;
        @(posedge clk);
        {lf_carrier_tick, lf_rc_tick, lf_header_ok} <= 3'b000;
        {preamble_start, preamble_byte_taken} <= 2'b00;
        #1 if (lf_chip_strobe === 1'b1) strb++;
    endtask : pulse

    task automatic test_map();
        for (int i = 0; i < 8; i++) begin
            HOST.rd(offs[i], rv);
            `CHK("reset value", rstv[i], rv)
        end
        `CHK("bias at reset", 8'h00, rf_receive_bias)
        HOST.bias_enable();
        cyc(1);
        `CHK("bias enabled", 8'h99, rf_receive_bias)
    endtask : test_map

    task automatic test_whiten_crc();
        logic [7:0] c;
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            c = {3'b000, i[2], i[1], i[0], 2'b11};
            b = 8'(8'h17 + 8'h31 * i);
            HOST.wr(bkz_pkg::OFF_WHITEN_CRC, c);
            pn_state <= {1'b1, b};
            cyc(3);
            `CHK("whiten byte", (i[2] ^ i[0]) ? rev8(b) : b, whiten_byte)
            `CHK("crc seed", i[1] ? 16'hffff : 16'h0000, crc_seed)
            HOST.rd(bkz_pkg::OFF_WHITEN_CRC, rv);
            `CHK("control readback", c & 8'h1c, rv)
        end
    endtask : test_whiten_crc

    task automatic test_symbol();
        logic [6:0] th [3] = '{7'd18, 7'd5, 7'd126};
        for (int t = 0; t < 3; t++) begin
            HOST.wr(bkz_pkg::OFF_LF_THRESHOLD, {1'b0, th[t]});
            for (int d = -1; d < 2; d++) begin
                @(posedge clk);
                lf_symbol_len <= 7'(th[t] + d);
                cyc(1);
                `CHK("symbol long", (d > 0) ? 1'b1 : 1'b0, lf_symbol_long)
            end
        end
        HOST.wr(bkz_pkg::OFF_LF_THRESHOLD, 8'h12);
    endtask : test_symbol

    task automatic test_preamble();
        HOST.wr(bkz_pkg::OFF_PREAMBLE, 8'ha3);
        cyc(1);
        `CHK("preamble byte", 8'ha3, preamble_byte)
        preamble_repeat_length <= 8'h00;
        pulse(3);
        cyc(1);
        `CHK("zero repeats", 1'b0, preamble_active)
        preamble_repeat_length <= 8'h03;
        pulse(3);
        cyc(1);
        `CHK("repeats loaded", 1'b1, preamble_active)
        for (int i = 2; i >= 0; i--) begin
            pulse(4);
            cyc(1);
            `CHK("repeats left", (i > 0) ? 1'b1 : 1'b0, preamble_active)
        end
    endtask : test_preamble

    task automatic test_lf_rx();
        int tb [6][4] = '{'{6, 25, 5, 0}, '{6, 25, 6, 1}, '{6, 25, 25, 1},
                          '{6, 25, 26, 0}, '{10, 12, 12, 1}, '{10, 12, 9, 0}};
        for (int r = 0; r < 6; r++) begin
            HOST.wr(bkz_pkg::OFF_LF_MIN_CNT, 8'(tb[r][0]));
            HOST.wr(bkz_pkg::OFF_LF_MAX_CNT, 8'(tb[r][1]));
            @(posedge clk);
            lf_enable <= 1'b1;
            cyc(2);
            `CHK("listening", bkz_pkg::BKZ_LF_LISTEN, lf_receive_fsm_state)
            pulse(0);
            repeat (tb[r][2]) pulse(1);
            repeat (2) pulse(0);
            cyc(2);
            `CHK("window result", tb[r][3] ? bkz_pkg::BKZ_LF_HEADER : bkz_pkg::BKZ_LF_LISTEN,
                 lf_receive_fsm_state)
            if (tb[r][3] != 0) begin
                pulse(2);
                cyc(2);
                `CHK("data state", bkz_pkg::BKZ_LF_DATA, lf_receive_fsm_state)
            end
            @(posedge clk);
            lf_enable <= 1'b0;
            cyc(2);
            `CHK("idle state", bkz_pkg::BKZ_LF_IDLE, lf_receive_fsm_state)
        end
    endtask : test_lf_rx

    task automatic test_lf_tx();
        int dv [6] = '{0, 1, 2, 5, 6, 31};
        int t;
        int seen;
        int ex;
        for (int k = 0; k < 6; k++) begin
            HOST.wr(bkz_pkg::OFF_LF_TX_DIV, 8'(dv[k]));
            @(posedge clk);
            lf_tx_run <= 1'b1;
            {t, seen, strb} = '0;
            for (int g = 0; g < 100 && seen < 4; g++) begin
                pulse(0);
                t++;
                if (strb > 0) begin
                    ex = (dv[k] < 2) ? 1 : (dv[k] + 1) / 2;
                    if (dv[k] > 0 && dv[k] % 2 == 0 && seen % 2 == 0) ex++;
                    `CHK("chip length", ex, t)
                    {t, strb} = '0;
                    seen++;
                    `CHK("chip odd", (seen % 2 == 0) ? 1'b1 : 1'b0, lf_chip_odd)
                end
            end
            `CHK("chips seen", 4, seen)
            @(posedge clk);
            lf_tx_run <= 1'b0;
            cyc(2);
        end
    endtask : test_lf_tx

    task automatic test_masks();
        for (int i = 0; i < 8; i++) begin
            HOST.wr(offs[i], 8'hff);
            HOST.rd(offs[i], rv);
            `CHK("write mask", mskv[i], rv)
        end
    endtask : test_masks

    task automatic final_report();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    initial begin
        {rst_b, lf_enable, lf_carrier_tick, lf_rc_tick, lf_header_ok, lf_tx_run} = '0;
        {preamble_start, preamble_byte_taken} = 2'b00;
        pn_state = 9'h000;
        preamble_repeat_length = 8'h00;
        lf_symbol_len = 7'h00;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        test_map();
        test_whiten_crc();
        test_symbol();
        test_preamble();
        test_lf_rx();
        test_lf_tx();
        test_masks();
        final_report();
    end

    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule : bkz_bank_regs_test
